// ===== design/tal_top.sv
// Temperature alarm block: control/status, limits, alarm and serial register access.
// Assumes cs_n, sclk and sio_in are synchronous to sys_clk and slow against it.
`timescale 1ns/1ps
module tal_top #(
    parameter logic [31:0] conv_base_cycles = 32'd1000000  // Cycles of a 13-bit conversion
) (
    input wire logic sys_clk,               // System clock, 100 MHz
    input wire logic resetn,                // Asynchronous reset, active low
    input wire logic cs_n,                  // Serial chip select, active low
    input wire logic sclk,                  // Serial clock from host
    input wire logic sio_in,                // Serial data pin input
    output logic sio_out,                   // Serial data pin output
    output logic sio_oe,                    // Serial data pin drive enable
    input wire logic [15:0] temp_sample,    // Raw converter result
    output logic heat_alarm_output          // Alarm pin
);
    // ==========================================
    // Declarations
    tal_conv_if conv ();
    logic power_down_request;
    logic alarm_disable;
    logic polarity;
    logic [1:0] res;
    logic [1:0] spare;
    logic [15:0] temp_result;
    logic [15:0] upper_limit;
    logic [15:0] lower_limit;
    logic alarm_state;
    logic upper_flag;
    logic lower_flag;
    logic result_valid_flag;
    logic toggle;
    logic conv_since_read;
    logic above_now;
    logic below_now;
    logic next_above;
    logic next_below;
    logic sclk_q;
    logic cs_q;
    logic rise;
    logic fall;
    logic [5:0] bit_cnt;
    logic [15:0] shifter;
    logic [7:0] cmd;
    logic [7:0] next_cmd;
    logic [15:0] next_wdata;
    logic read_phase;
    logic ctrl_read;
    logic ctrl_write;
    logic alarm_clear;
    logic next_toggle;
    logic [15:0] ctrl_value;
    logic [15:0] read_value;

    // ==========================================
    // Serial edge detection
    assign rise = !cs_n && sclk && !sclk_q;
    assign fall = !cs_n && !sclk && sclk_q;
    assign next_cmd = {cmd[6:0], sio_in};
    assign next_wdata = {shifter[14:0], sio_in};

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            sclk_q <= 1'b0;
            cs_q <= 1'b1;
        end
        else
        begin
            sclk_q <= sclk;
            cs_q <= cs_n;
        end
    end

    // ==========================================
    // Register access strobes
    // command code decode
    assign ctrl_read = rise && (bit_cnt == tal_pkg::CMD_LAST) && (next_cmd == tal_pkg::CMD_CTRL_RD);
    assign ctrl_write = rise && (bit_cnt == tal_pkg::DATA_LAST) && (cmd == tal_pkg::CMD_CTRL_WR);
    assign alarm_clear = ctrl_write && next_wdata[tal_pkg::BIT_ALARM_CLEAR];
    assign next_toggle = toggle ^ conv_since_read;

    assign ctrl_value = {power_down_request, 1'b0, 1'b0, next_toggle,
                         !alarm_disable && heat_alarm_output, upper_flag, lower_flag,
                         result_valid_flag, alarm_disable, polarity, res, 1'b0, spare, 1'b0};

    always_comb
    begin
        case (next_cmd)
            tal_pkg::CMD_CTRL_RD: read_value = ctrl_value;
            tal_pkg::CMD_UPPER_RD: read_value = upper_limit;
            tal_pkg::CMD_LOWER_RD: read_value = lower_limit;
            default: read_value = 16'h0000;
        endcase
    end

    // ==========================================
    // Serial frame: 16 result bits out, command in, data in or out
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            bit_cnt <= 6'd0;
            cmd <= 8'h00;
            read_phase <= 1'b0;
        end
        else if (cs_n)
        begin
            bit_cnt <= 6'd0;
            read_phase <= 1'b0;
        end
        else if (rise)
        begin
            if (bit_cnt != 6'd63)
                bit_cnt <= bit_cnt + 6'd1;
            if (bit_cnt >= tal_pkg::TEMP_BITS && bit_cnt <= tal_pkg::CMD_LAST)
                cmd <= next_cmd;
            // read bit selects direction
            // Illegal codes with the read bit still drive zeros back
            if (bit_cnt == tal_pkg::CMD_LAST)
                read_phase <= next_cmd[7];
        end
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            shifter <= 16'h0000;
        else if (cs_q && !cs_n)
            shifter <= temp_result;
        else if (rise && bit_cnt == tal_pkg::CMD_LAST)
            shifter <= read_value;
        else if (rise && bit_cnt >= tal_pkg::DATA_FIRST && !read_phase)
            shifter <= next_wdata;
        else if (fall && read_phase && bit_cnt != tal_pkg::DATA_FIRST)
            shifter <= {shifter[14:0], 1'b0};
        else if (fall && bit_cnt < tal_pkg::TEMP_BITS)
            shifter <= {shifter[14:0], 1'b0};
    end

    assign sio_out = shifter[15];
    assign sio_oe = !cs_n && ((bit_cnt < tal_pkg::TEMP_BITS) || (read_phase && bit_cnt >= tal_pkg::DATA_FIRST));

    // ==========================================
    // Control fields
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            power_down_request <= tal_pkg::CTRL_RESET[tal_pkg::BIT_POWER_DOWN];
            alarm_disable <= tal_pkg::CTRL_RESET[tal_pkg::BIT_ALARM_DISABLE];
            polarity <= tal_pkg::CTRL_RESET[tal_pkg::BIT_POLARITY];
            res <= tal_pkg::CTRL_RESET[tal_pkg::BIT_RES_HI:tal_pkg::BIT_RES_LO];
            spare <= tal_pkg::CTRL_RESET[tal_pkg::BIT_SPARE_HI:tal_pkg::BIT_SPARE_LO];
        end
        else if (ctrl_write)
        begin
            power_down_request <= next_wdata[tal_pkg::BIT_POWER_DOWN];
            alarm_disable <= next_wdata[tal_pkg::BIT_ALARM_DISABLE];
            polarity <= next_wdata[tal_pkg::BIT_POLARITY];
            res <= next_wdata[tal_pkg::BIT_RES_HI:tal_pkg::BIT_RES_LO];
            spare <= next_wdata[tal_pkg::BIT_SPARE_HI:tal_pkg::BIT_SPARE_LO];
        end
    end

    // ==========================================
    // Limit registers
    // low bits stay zero
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            upper_limit <= tal_pkg::UPPER_RESET;
            lower_limit <= tal_pkg::LOWER_RESET;
        end
        else if (rise && bit_cnt == tal_pkg::DATA_LAST)
        begin
            if (cmd == tal_pkg::CMD_UPPER_WR)
                upper_limit <= {next_wdata[15:tal_pkg::LIMIT_LSB], 5'b0_0000};
            if (cmd == tal_pkg::CMD_LOWER_WR)
                lower_limit <= {next_wdata[15:tal_pkg::LIMIT_LSB], 5'b0_0000};
        end
    end

    // ==========================================
    // Conversion control
    assign conv.run_cont = !power_down_request;
    assign conv.res = res;
    assign conv.one_shot = ctrl_write && next_wdata[tal_pkg::BIT_ONE_SHOT] && next_wdata[tal_pkg::BIT_POWER_DOWN];

    tal_conv_seq #(
        .conv_base_cycles(conv_base_cycles)
    ) u_seq (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .conv(conv.seq)
    );

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            temp_result <= 16'h0000;
        else if (conv.done)
            temp_result <= tal_pkg::tal_mask_res(temp_sample, res);
    end

    tal_limit_cmp u_cmp_now (
        .result(temp_result),
        .upper(upper_limit),
        .lower(lower_limit),
        .above(above_now),
        .below(below_now)
    );

    tal_limit_cmp u_cmp_next (
        .result(tal_pkg::tal_mask_res(temp_sample, res)),
        .upper(upper_limit),
        .lower(lower_limit),
        .above(next_above),
        .below(next_below)
    );

    // ==========================================
    // Alarm state; a conversion end above the upper limit wins over a host clear
    // evaluated at conversion end
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            alarm_state <= 1'b0;
        else if (conv.done && next_above)
            alarm_state <= 1'b1;
        else if (conv.done && next_below)
            alarm_state <= 1'b0;
        else if (alarm_clear)
            alarm_state <= 1'b0;
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            heat_alarm_output <= 1'b1;
        else
            heat_alarm_output <= (alarm_state && !alarm_disable && !(conv.done && next_below && !next_above)
                                  && !(alarm_clear && !(conv.done && next_above))) ? polarity : !polarity;
    end

    // ==========================================
    // Limit flags
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            upper_flag <= 1'b0;
            lower_flag <= 1'b0;
        end
        else
        begin
            // clear when read and not above
            if (conv.done && next_above)
                upper_flag <= 1'b1;
            else if (ctrl_read && !above_now)
                upper_flag <= 1'b0;
            // clear when read and not below
            if (conv.done && next_below)
                lower_flag <= 1'b1;
            else if (ctrl_read && !below_now)
                lower_flag <= 1'b0;
        end
    end

    // ==========================================
    // Data available and conversion toggle
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            result_valid_flag <= 1'b0;
            conv_since_read <= 1'b0;
            toggle <= 1'b0;
        end
        else
        begin
            // set on end, cleared by read
            if (conv.done)
                result_valid_flag <= 1'b1;
            else if (ctrl_read)
                result_valid_flag <= 1'b0;
            if (conv.done)
                conv_since_read <= 1'b1;
            else if (ctrl_read)
                conv_since_read <= 1'b0;
            if (ctrl_read)
                toggle <= next_toggle;
        end
    end

    // ==========================================
    // Checks
    // valid after conversion
    valid_set_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        conv.done |=> result_valid_flag)
        else $error("data available not set after conversion");

    valid_clear_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (ctrl_read && !conv.done) |=> !result_valid_flag)
        else $error("data available not cleared by read");

    alarm_raise_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (conv.done && next_above && !alarm_disable) |=> alarm_state ##1 (heat_alarm_output == $past(polarity)))
        else $error("alarm not raised above upper limit");

    alarm_clear_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (alarm_clear && !conv.done) |=> (!alarm_state && heat_alarm_output != $past(polarity)))
        else $error("alarm not cleared by host");

    alarm_low_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (conv.done && next_below && !next_above) |=> !alarm_state)
        else $error("alarm held after low result");

    upper_hold_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (upper_flag && !ctrl_read) |=> upper_flag)
        else $error("upper flag lost without read");

    lower_set_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (conv.done && next_below) |=> lower_flag)
        else $error("lower flag not set");

    toggle_flip_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (ctrl_read && conv_since_read) |=> (toggle != $past(toggle)))
        else $error("toggle bit did not invert");

    alarm_off_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (alarm_disable && $past(alarm_disable)) |-> (heat_alarm_output != $past(polarity)))
        else $error("disabled alarm pin active");
endmodule // tal_top

// ===== design/tal_pkg.sv
// Package: shared constants and types for the temperature alarm and limit block.
// Assumes a single 100 MHz clock and an asynchronous active-low reset.
package tal_pkg;

    // ==========================================
    // Command codes of the serial link
    localparam logic [7:0] CMD_CTRL_RD = 8'h81;
    localparam logic [7:0] CMD_CTRL_WR = 8'h01;
    localparam logic [7:0] CMD_UPPER_RD = 8'h82;
    localparam logic [7:0] CMD_UPPER_WR = 8'h02;
    localparam logic [7:0] CMD_LOWER_RD = 8'h83;
    localparam logic [7:0] CMD_LOWER_WR = 8'h03;

    // ==========================================
    // Control and status field positions
    localparam int BIT_POWER_DOWN = 15;
    localparam int BIT_ONE_SHOT = 14;
    localparam int BIT_ALARM_CLEAR = 13;
    localparam int BIT_TOGGLE = 12;
    localparam int BIT_ALARM_STATUS = 11;
    localparam int BIT_UPPER_FLAG = 10;
    localparam int BIT_LOWER_FLAG = 9;
    localparam int BIT_VALID = 8;
    localparam int BIT_ALARM_DISABLE = 7;
    localparam int BIT_POLARITY = 6;
    localparam int BIT_RES_HI = 5;
    localparam int BIT_RES_LO = 4;
    localparam int BIT_SPARE_HI = 2;
    localparam int BIT_SPARE_LO = 1;
    localparam int LIMIT_LSB = 5;

    // ==========================================
    // Reset values
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [15:0] UPPER_RESET = 16'h4880;
    localparam logic [15:0] LOWER_RESET = 16'h4600;

    // ==========================================
    // Frame layout, counted in clock rises of the serial link
    localparam logic [5:0] TEMP_BITS = 6'd16;
    localparam logic [5:0] CMD_LAST = 6'd23;
    localparam logic [5:0] DATA_FIRST = 6'd24;
    localparam logic [5:0] DATA_LAST = 6'd39;

    typedef enum logic [0:0] {
        SEQ_IDLE = 1'b0,
        SEQ_CONVERT = 1'b1
    } tal_seq_state_type;

    // Zero the result bits below the selected resolution
    function automatic logic [15:0] tal_mask_res(input logic [15:0] value, input logic [1:0] res);
        logic [15:0] mask;
        mask = 16'hFFFF << (2'd3 - res);
        return value & mask;
    endfunction

endpackage

// ===== design/tal_conv_if.sv
// Interface: handshake between register logic and conversion sequencer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface tal_conv_if;
    logic run_cont;     // Continuous conversion allowed
    logic one_shot;     // Single conversion request pulse
    logic [1:0] res;    // Resolution code
    logic busy;         // Conversion in progress
    logic done;         // Conversion finished pulse

    modport ctrl (output run_cont, output one_shot, output res, input busy, input done);
    modport seq (input run_cont, input one_shot, input res, output busy, output done);
endinterface

// ===== design/tal_conv_seq.sv
// Conversion sequencer: times each conversion from the resolution code.
// Assumes the analog result is valid whenever done pulses.
`timescale 1ns/1ps
module tal_conv_seq #(
    parameter logic [31:0] conv_base_cycles = 32'd1000000
) (
    input wire logic sys_clk,   // System clock
    input wire logic resetn,    // Asynchronous reset, active low
    tal_conv_if.seq conv        // Conversion handshake
);
    tal_pkg::tal_seq_state_type state;
    logic [35:0] count;
    logic pending;
    logic [35:0] span;

    assign span = {4'h0, conv_base_cycles} << conv.res;
    assign conv.busy = (state == tal_pkg::SEQ_CONVERT);
    assign conv.done = conv.busy && (count == span - 36'd1);

    // ==========================================
    // Single conversion request held until a conversion starts
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            pending <= 1'b0;
        else if (conv.one_shot)
            pending <= 1'b1;
        else if (state == tal_pkg::SEQ_IDLE)
            pending <= 1'b0;
    end

    // ==========================================
    // finish before stopping
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state <= tal_pkg::SEQ_IDLE;
            count <= 36'h0_0000_0000;
        end
        else
        begin
            case (state)
                tal_pkg::SEQ_IDLE:
                begin
                    count <= 36'h0_0000_0000;
                    if (conv.run_cont || pending)
                        state <= tal_pkg::SEQ_CONVERT;
                end
                tal_pkg::SEQ_CONVERT:
                begin
                    if (conv.done)
                    begin
                        count <= 36'h0_0000_0000;
                        if (!conv.run_cont)
                            state <= tal_pkg::SEQ_IDLE;
                    end
                    else
                        count <= count + 36'd1;
                end
                default:
                    state <= tal_pkg::SEQ_IDLE;
            endcase
        end
    end

    idle_hold_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (state == tal_pkg::SEQ_IDLE && !conv.run_cont && !pending && !conv.one_shot)
        |=> (state == tal_pkg::SEQ_IDLE))
        else $error("conversion started during shutdown without request");

    conv_hold_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (conv.busy && !conv.done) |=> conv.busy)
        else $error("conversion stopped before its end");

    one_shot_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (conv.one_shot && state == tal_pkg::SEQ_IDLE) |=> ##1 conv.busy)
        else $error("single conversion did not start");
endmodule // tal_conv_seq

// ===== design/tal_limit_cmp.sv
// Limit comparator: signed compare of a result against both limits.
// Assumes limits hold their value in bits 15:5, low bits zero.
`timescale 1ns/1ps
module tal_limit_cmp (
    input wire logic [15:0] result,  // Temperature result, stored or about to be stored
    input wire logic [15:0] upper,   // Upper limit register
    input wire logic [15:0] lower,   // Lower limit register
    output logic above,              // Result exceeds upper limit
    output logic below               // Result below lower limit
);
    assign above = $signed(result) > $signed(upper);
    assign below = $signed(result) < $signed(lower);
endmodule // tal_limit_cmp

// ===== verif/tal_host_model.sv
// Host model: drives whole frames on the three-wire link.
// Assumes signals move at sys_clk falling edges; sclk idles low.
`timescale 1ns/1ps
module tal_host_model (
    input wire logic sys_clk, // System clock
    input wire logic sio_out, // Device data
    input wire logic sio_oe,  // Device drive enable
    output logic cs_n,        // Select, active low
    output logic sclk,        // Serial clock
    output logic sio_in       // Resolved data line
);
    logic ho;
    logic hd;
    initial {cs_n, sclk, ho, hd, sio_in} = 5'b10000;
    // Released line flips every cycle
    always @(negedge sys_clk) sio_in <= sio_oe ? sio_out : (ho ? hd : ~sio_in);
    // ====================
    // Frame: result, command, data
    task automatic frame(input logic [7:0] cmd, input logic [15:0] wd, output logic [15:0] tr,
                         output logic [15:0] rd);
        logic [39:0] tx;
        logic [39:0] rx;
        tx = {16'h0000, cmd, wd};
        @(negedge sys_clk) cs_n <= 1'b0;
        repeat (3) @(negedge sys_clk);
        for (int i = 39; i >= 0; i--)
        begin
            ho <= (i < 24) && (i >= 16 || !cmd[7]);
            hd <= tx[i];
            repeat (3) @(negedge sys_clk);
            sclk <= 1'b1;
            rx[i] = sio_in;
            repeat (3) @(negedge sys_clk);
            sclk <= 1'b0;
        end
        {cs_n, ho} <= 2'b10;
        tr = rx[39:24];
        rd = rx[15:0];
    endtask
endmodule // tal_host_model

// ===== verif/testbench.sv
// Testbench: random and corner frames against the alarm block.
// Assumes tal_host_model as the host.
`timescale 1ns/1ps
module testbench;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic [15:0] temp_sample = 16'h4700;
    logic cs_n, sclk, sio_in, sio_out, sio_oe, heat_alarm_output;
    logic [15:0] t, v, w;
    logic tg;
    logic [7:0] bad_cmd [6] = '{8'h80, 8'h84, 8'h85, 8'h86, 8'h87, 8'hC1};
    int bad_count = 0;
    int checks_done = 0;
    int cycles = 0;
    always #5 sys_clk = ~sys_clk;
    tal_host_model host (.sys_clk(sys_clk), .sio_out(sio_out), .sio_oe(sio_oe), .cs_n(cs_n), .sclk(sclk),
                         .sio_in(sio_in));
    tal_top #(.conv_base_cycles(32'd20)) dut (.sys_clk(sys_clk), .resetn(resetn), .cs_n(cs_n), .sclk(sclk),
        .sio_in(sio_in), .sio_out(sio_out), .sio_oe(sio_oe), .temp_sample(temp_sample),
        .heat_alarm_output(heat_alarm_output));
    // ====================
    // Helpers
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic pin(input logic e);
        chk("pin", {15'h0000, heat_alarm_output}, {15'h0000, e});
    endtask
    task automatic xfer(input logic [7:0] c, input logic [15:0] d, input int gap);
        host.frame(c, d, t, v);
        repeat (gap) @(negedge sys_clk);
    endtask
    function automatic logic [15:0] msk(input logic [15:0] x, input int r);
        return x & (16'hFFFF << (3 - r));
    endfunction
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            bad_count++;
            wrap_up();
        end
    end
    // ====================
    // Main sequence
    initial
    begin
        void'($urandom(81));
        repeat (3) @(negedge sys_clk);
        pin(1'b1);
        resetn = 1'b1;
        repeat (30) @(negedge sys_clk);
        xfer(8'h81, 16'h0000, 0);
        chk("ctrl", v, 16'h1900);
        chk("temp", t, 16'h4700);
        xfer(8'h82, 16'h0000, 0);
        chk("upper", v, 16'h4880);
        xfer(8'h83, 16'h0000, 0);
        chk("lower", v, 16'h4600);
        foreach (bad_cmd[i])
        begin
            xfer(bad_cmd[i], 16'h0000, 0);
            chk("illegal", v, 16'h0000);
        end
        for (int i = 2; i < 4; i++)
        begin
            w = (i == 2) ? {3'b011, 13'($urandom)} : {2'b00, 14'($urandom)};
            xfer(8'(i), w, 0);
            xfer(8'(i) | 8'h80, 16'h0000, 0);
            chk("limit", v, w & 16'hFFE0);
        end
        xfer(8'h02, 16'h4880, 0);
        xfer(8'h03, 16'h4600, 0);
        temp_sample = 16'h4900;
        xfer(8'h81, 16'h0000, 100);
        pin(1'b0);
        xfer(8'h81, 16'h0000, 0);
        chk("over", v & 16'hEFFF, 16'h0500);
        xfer(8'h01, 16'h8000, 200);
        xfer(8'h01, 16'hA000, 5);
        pin(1'b1);
        xfer(8'h81, 16'h0000, 0);
        chk("clear", v & 16'hEFFF, 16'h8D00);
        tg = v[12];
        xfer(8'h81, 16'h0000, 0);
        chk("reread", v, {3'b100, tg, 12'hC00});
        xfer(8'h01, 16'hC000, 60);
        pin(1'b0);
        xfer(8'h81, 16'h0000, 0);
        chk("shot", v, {3'b100, ~tg, 12'h500});
        chk("shot_temp", t, 16'h4900);
        temp_sample = 16'h4500;
        xfer(8'h01, 16'hC000, 60);
        pin(1'b1);
        xfer(8'h81, 16'h0000, 0);
        chk("below", v & 16'hEFFF, 16'h8F00);
        xfer(8'h81, 16'h0000, 0);
        chk("hist", v & 16'hEFFF, 16'h8A00);
        temp_sample = 16'h4700;
        xfer(8'h01, 16'hC000, 60);
        xfer(8'h81, 16'h0000, 0);
        xfer(8'h81, 16'h0000, 0);
        chk("mid", v & 16'hEFFF, 16'h8800);
        for (int r = 0; r < 4; r++)
        begin
            w = 16'(r << 4) | (16'($urandom) & 16'h0006);
            temp_sample = 16'($urandom);
            xfer(8'h01, 16'hC000 | w, 200);
            xfer(8'h81, 16'h0000, 0);
            chk("res", v & 16'hE0F6, 16'h8000 | w);
            chk("res_temp", t, msk(temp_sample, r));
        end
        temp_sample = 16'h4900;
        xfer(8'h01, 16'hC040, 60);
        pin(1'b1);
        xfer(8'h01, 16'h80C0, 5);
        pin(1'b0);
        xfer(8'h81, 16'h0000, 0);
        chk("dis", v & 16'h08C0, 16'h00C0);
        xfer(8'h01, 16'h4000, 100);
        xfer(8'h81, 16'h0000, 100);
        xfer(8'h81, 16'h0000, 0);
        chk("cont", v & 16'hC100, 16'h0100);
        xfer(8'h09, 16'h8000, 0);
        xfer(8'h81, 16'h0000, 0);
        chk("badwr", v & 16'h8000, 16'h0000);
        wrap_up();
    end
endmodule // testbench
